/* File: phase_cfg_pkg.sv */
// Constants, register map and state type for phase detection and interleave
package phase_cfg_pkg;
  // --------------------------------------------------------------------
  // Clock and detection timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int DETECT_TIME_NS   = 30000;
  localparam int DETECT_CYCLES    = (DETECT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int DET_CNT_W        = 16;

  // --------------------------------------------------------------------
  // Register map and fields
  // --------------------------------------------------------------------
  localparam logic [7:0] REG_OSC_SEL   = 8'hf7;
  localparam logic [7:0] REG_STATUS    = 8'hf8;
  localparam logic [7:0] OSC_SEL_RST   = 8'h00;
  localparam int         OSC_OVR_BIT   = 5;
  localparam int         OSC_CODE_W    = 5;

  // --------------------------------------------------------------------
  // Ramp oscillator: phase accumulator and per-count spacing
  // --------------------------------------------------------------------
  localparam int          ACC_W    = 16;
  localparam logic [15:0] INC_MIN  = 16'h0042;
  localparam logic [15:0] INC_STEP = 16'h0009;
  localparam logic [15:0] SPACE_1  = 16'h0000;
  localparam logic [15:0] SPACE_2  = 16'h8000;
  localparam logic [15:0] SPACE_3  = 16'h5555;
  localparam logic [15:0] SPACE_4  = 16'h4000;
  localparam logic [15:0] HALF_1   = 16'h8000;
  localparam logic [15:0] HALF_2   = 16'h4000;
  localparam logic [15:0] HALF_3   = 16'h2aab;
  localparam logic [15:0] HALF_4   = 16'h2000;

  // --------------------------------------------------------------------
  // Phase counts and sequencer states
  // --------------------------------------------------------------------
  localparam logic [2:0] PH_1 = 3'h1;
  localparam logic [2:0] PH_2 = 3'h2;
  localparam logic [2:0] PH_3 = 3'h3;
  localparam logic [2:0] PH_4 = 3'h4;
  localparam int         N_MAIN = 4;

  // Driven main channels per count; tied straps float their matching outputs
  localparam logic [3:0] USE_1 = 4'h1;
  localparam logic [3:0] USE_2 = 4'h5;
  localparam logic [3:0] USE_3 = 4'h7;
  localparam logic [3:0] USE_4 = 4'hf;

  typedef enum logic [1:0] {ST_IDLE, ST_DETECT, ST_RUN} seq_state_t;
endpackage

/* File: phase_count_detect.sv */
// Start-up phase detection, PWM output configuration and ramp interleave
`timescale 1ns/100ps
`default_nettype none
// Function
// RL1: No strap tied high selects four main-rail phases.
// RL2: Strap4 gives three, straps 2+4 give two, straps 2+3+4 give one phase.
// RL3: Second-rail strap tied high disables the second rail only.
// RL4: While enabled and before soft start, sink current on straps 2 to 4.
// RL5: A strap above threshold counts as tied, otherwise not tied.
// RL6: Phase 1 output held low for the whole fixed detection interval.
// RL7: After detection remove sinks and run untied phases normally.
// RL8: Tied straps lose their sink; matching outputs go high impedance.
// RL9: Each phase output is independent; overlap and near full duty allowed.
// RL10: Frequency from resistor code or register, 32 steps.
// RL11: Main ramps equally spaced; second rail halfway between phases 1 and 2.
// RL12: Ramp supply lockout acts only while enabled.
// RL13: Steady-state pulses centre on ramp valley, both edges modulated.
// RL14: Outputs at mid level after detection until each phase's first pulse.
// RL15: Latch configuration at detection end; hold until enable drops.
module phase_count_detect
  import phase_cfg_pkg::*;
#(
  parameter int DETECT_CNT = phase_cfg_pkg::DETECT_CYCLES
) (
  input  wire logic                  clk,                     // 200 MHz clock
  input  wire logic                  rst_n,                   // Async reset, low
  input  wire logic                  enable,                  // Controller enable
  input  wire logic                  phase_sense_strap_2,     // Strap 2 comparator
  input  wire logic                  phase_sense_strap_3,     // Strap 3 comparator
  input  wire logic                  phase_sense_strap_4,     // Strap 4 comparator
  input  wire logic                  second_rail_sense_strap, // Second rail strap
  input  wire logic                  ramp_supply_sense_pin,   // Ramp supply above 4 V
  input  wire logic [phase_cfg_pkg::OSC_CODE_W-1:0] rosc_code, // Resistor code
  input  wire logic [7:0]            main_demand,             // Main error level
  input  wire logic [7:0]            second_demand,           // Second rail level
  input  wire logic                  reg_wr,                  // Register write
  input  wire logic                  reg_rd,                  // Register read
  input  wire logic [7:0]            reg_addr,                // Register address
  input  wire logic [7:0]            reg_wdata,               // Write data
  output logic [7:0]                 reg_rdata,               // Read data
  output logic [2:0]                 strap_sink_on,           // Sinks, straps 4..2
  output logic                       phase1_pulse_out,        // Phase 1 level
  output logic                       phase1_pulse_oe,         // Phase 1 driven
  output logic                       phase1_pulse_mid,        // Phase 1 mid level
  output logic                       phase2_pulse_out,        // Phase 2 level
  output logic                       phase2_pulse_oe,         // Phase 2 driven
  output logic                       phase2_pulse_mid,        // Phase 2 mid level
  output logic                       phase3_pulse_out,        // Phase 3 level
  output logic                       phase3_pulse_oe,         // Phase 3 driven
  output logic                       phase3_pulse_mid,        // Phase 3 mid level
  output logic                       phase4_pulse_out,        // Phase 4 level
  output logic                       phase4_pulse_oe,         // Phase 4 driven
  output logic                       phase4_pulse_mid,        // Phase 4 mid level
  output logic                       second_rail_pulse_out,   // Second rail level
  output logic                       second_rail_pulse_oe,    // Second rail driven
  output logic                       second_rail_pulse_mid,   // Second rail mid
  output logic [2:0]                 phase_count,             // Latched count
  output logic                       second_rail_off,         // Second rail disabled
  output logic                       soft_start_go,           // Detection complete
  output logic                       supply_low_lockout       // Ramp supply lockout
);
  import phase_cfg_pkg::*;

  localparam int NCH = N_MAIN + 1;

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------
  logic rst_m_q;
  logic rst_s_n;

  // Second stage only feeds the design
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_n <= rst_m_q;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer and detection timer
  // ----------------------------------------------------------------------
  seq_state_t           st_q;
  logic [DET_CNT_W-1:0] det_cnt_q;
  logic                 det_done;
  logic [2:0]           dec_count;

  assign det_done = (st_q == ST_DETECT) && (det_cnt_q == DET_CNT_W'(DETECT_CNT - 1));

  // Enable low acts as the sequence reset, so each enable re-detects
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      st_q <= ST_IDLE;
    end else if (!enable) begin
      st_q <= ST_IDLE; // [RL15]
    end else begin
      unique case (st_q)
        ST_IDLE:   st_q <= ST_DETECT;
        ST_DETECT: st_q <= det_done ? ST_RUN : ST_DETECT; // [RL6]
        ST_RUN:    st_q <= ST_RUN;
      endcase
    end
  end

  // Interval counter runs only inside detection
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      det_cnt_q <= '0;
    end else if (st_q == ST_DETECT && enable) begin
      det_cnt_q <= det_cnt_q + DET_CNT_W'(1); // [RL6]
    end else begin
      det_cnt_q <= '0;
    end
  end

  strap_phase_decode u_decode (
    .tied_2 (phase_sense_strap_2),
    .tied_3 (phase_sense_strap_3),
    .tied_4 (phase_sense_strap_4),
    .count  (dec_count)
  );

  // Straps are sampled once, in the last cycle of the interval
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      phase_count     <= PH_4;
      second_rail_off <= 1'b0;
    end else if (det_done && enable) begin
      phase_count     <= dec_count;               // [RL1] [RL2] [RL5] [RL15]
      second_rail_off <= second_rail_sense_strap; // [RL3]
    end
  end

  // Sinks pull untied straps low only during the probe
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      strap_sink_on <= '0;
      soft_start_go <= 1'b0;
    end else begin
      strap_sink_on <= (enable && st_q != ST_RUN && !det_done) ? 3'h7 : 3'h0; // [RL4] [RL7]
      soft_start_go <= enable && (det_done || st_q == ST_RUN);
    end
  end

  // ----------------------------------------------------------------------
  // Frequency select register and status readback
  // ----------------------------------------------------------------------
  logic [7:0] osc_sel_q;

  // Written value survives enable cycling
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      osc_sel_q <= OSC_SEL_RST;
    end else if (reg_wr && reg_addr == REG_OSC_SEL) begin
      osc_sel_q <= reg_wdata; // [RL10]
    end
  end

  // Unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == REG_OSC_SEL) begin
        reg_rdata <= osc_sel_q;
      end else if (reg_addr == REG_STATUS) begin
        reg_rdata <= {3'h0, st_q == ST_RUN, second_rail_off, phase_count};
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Ramp oscillator and phase offsets
  // ----------------------------------------------------------------------
  logic [OSC_CODE_W-1:0] code;
  logic [ACC_W-1:0]      inc;
  logic [ACC_W-1:0]      acc_q;
  logic [ACC_W-1:0]      space;
  logic [ACC_W-1:0]      half;
  logic [NCH-1:0]        chan_pulse;
  logic [NCH-1:0]        active;
  logic [N_MAIN-1:0]     main_mask;

  // Register override wins over the resistor code
  assign code = osc_sel_q[OSC_OVR_BIT] ? osc_sel_q[OSC_CODE_W-1:0] : rosc_code; // [RL10]
  assign inc  = INC_MIN + ACC_W'(code * INC_STEP);

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_q + inc;
    end
  end

  // Spacing is a full turn over the count; two phases run on channels 1 and 3,
  // so quarter steps put channel 3 half a turn from channel 1
  always_comb begin
    unique case (phase_count)
      PH_1:    begin space = SPACE_1; half = HALF_1; main_mask = USE_1; end
      PH_2:    begin space = SPACE_4; half = HALF_2; main_mask = USE_2; end
      PH_3:    begin space = SPACE_3; half = HALF_3; main_mask = USE_3; end
      default: begin space = SPACE_4; half = HALF_4; main_mask = USE_4; end
    endcase
  end

  // Main phases, one channel each, fully independent
  for (genvar i = 0; i < N_MAIN; i++) begin : g_main
    ramp_phase_channel #(.AW(ACC_W), .DW(8)) u_ch (
      .clk     (clk),
      .rst_s_n (rst_s_n),
      .run     (st_q == ST_RUN),
      .acc     (acc_q),
      .offset  (ACC_W'(i * space)), // [RL11] [RL13]
      .demand  (main_demand),
      .pulse_q (chan_pulse[i])
    );
    assign active[i] = main_mask[i]; // [RL8]
  end

  // Second rail halfway between main phases 1 and 2
  ramp_phase_channel #(.AW(ACC_W), .DW(8)) u_second (
    .clk     (clk),
    .rst_s_n (rst_s_n),
    .run     (st_q == ST_RUN),
    .acc     (acc_q),
    .offset  (half), // [RL11]
    .demand  (second_demand),
    .pulse_q (chan_pulse[N_MAIN])
  );
  assign active[N_MAIN] = !second_rail_off;

  // ----------------------------------------------------------------------
  // Ramp supply lockout
  // ----------------------------------------------------------------------
  // Disabled pin is high impedance, so its level means nothing then
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      supply_low_lockout <= 1'b0;
    end else begin
      supply_low_lockout <= enable && !ramp_supply_sense_pin; // [RL12]
    end
  end

  // ----------------------------------------------------------------------
  // Output stage: level, enable and mid state per channel
  // ----------------------------------------------------------------------
  logic [NCH-1:0] out_q;
  logic [NCH-1:0] oe_q;
  logic [NCH-1:0] mid_q;
  logic           running;

  assign running = (st_q == ST_RUN) && enable && !supply_low_lockout;

  // Low while idle or probing; unused channels float after detection
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      out_q <= '0;
      oe_q  <= '1;
    end else if (st_q == ST_RUN && enable) begin
      out_q <= running ? (chan_pulse & active & ~mid_q) : '0; // [RL9]
      oe_q  <= active; // [RL8] [RL3]
    end else begin
      out_q <= '0; // [RL6]
      oe_q  <= '1;
    end
  end

  // Mid state released by the first real pulse of each channel
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      mid_q <= '0;
    end else if (det_done && enable) begin
      mid_q <= '1; // [RL14]
    end else if (st_q != ST_RUN || !enable) begin
      mid_q <= '0;
    end else if (running) begin
      mid_q <= mid_q & ~chan_pulse; // [RL14]
    end
  end

  assign phase1_pulse_out      = out_q[0];
  assign phase2_pulse_out      = out_q[1];
  assign phase3_pulse_out      = out_q[2];
  assign phase4_pulse_out      = out_q[3];
  assign second_rail_pulse_out = out_q[4];
  assign phase1_pulse_oe       = oe_q[0];
  assign phase2_pulse_oe       = oe_q[1];
  assign phase3_pulse_oe       = oe_q[2];
  assign phase4_pulse_oe       = oe_q[3];
  assign second_rail_pulse_oe  = oe_q[4];
  assign phase1_pulse_mid      = mid_q[0];
  assign phase2_pulse_mid      = mid_q[1];
  assign phase3_pulse_mid      = mid_q[2];
  assign phase4_pulse_mid      = mid_q[3];
  assign second_rail_pulse_mid = mid_q[4];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s_n);

  property p_four_default;
    det_done && enable && !phase_sense_strap_2 && !phase_sense_strap_3
      && !phase_sense_strap_4 |=> phase_count == PH_4;
  endproperty
  a_four_default: assert property (p_four_default) // [RL1]
    else $error("no tied strap did not give four phases");

  property p_two_phase;
    det_done && enable && phase_sense_strap_2 && !phase_sense_strap_3
      && phase_sense_strap_4 |=> phase_count == PH_2 ##1 phase_count == PH_2;
  endproperty
  a_two_phase: assert property (p_two_phase) // [RL2]
    else $error("straps 2 and 4 did not give two phases");

  property p_second_off;
    det_done && enable && second_rail_sense_strap |=> ##1 !second_rail_pulse_oe;
  endproperty
  a_second_off: assert property (p_second_off) // [RL3]
    else $error("second rail still driven with its strap tied");

  property p_sink_probe;
    st_q == ST_DETECT && enable && !det_done |=> strap_sink_on == 3'h7;
  endproperty
  a_sink_probe: assert property (p_sink_probe) // [RL4]
    else $error("strap sinks off during detection");

  property p_p1_low;
    $past(st_q) == ST_DETECT |-> !phase1_pulse_out && phase1_pulse_oe;
  endproperty
  a_p1_low: assert property (p_p1_low) // [RL6]
    else $error("phase 1 not held low during detection");

  property p_detect_len;
    $rose(st_q == ST_RUN) |-> $past(det_cnt_q) == DET_CNT_W'(DETECT_CNT - 1);
  endproperty
  a_detect_len: assert property (p_detect_len) // [RL6]
    else $error("detection interval length wrong");

  property p_sink_off;
    st_q == ST_RUN |-> strap_sink_on == 3'h0;
  endproperty
  a_sink_off: assert property (p_sink_off) // [RL7]
    else $error("strap sinks left on after detection");

  property p_unused_float;
    st_q == ST_RUN && enable && phase_count < PH_4 |=> !phase4_pulse_oe;
  endproperty
  a_unused_float: assert property (p_unused_float) // [RL8]
    else $error("unused phase 4 still driven");

  property p_lock_gate;
    !enable |=> !supply_low_lockout;
  endproperty
  a_lock_gate: assert property (p_lock_gate) // [RL12]
    else $error("lockout active while disabled");

  property p_mid_hold;
    phase1_pulse_mid && !chan_pulse[0] && st_q == ST_RUN && enable
      |=> phase1_pulse_mid && !phase1_pulse_out;
  endproperty
  a_mid_hold: assert property (p_mid_hold) // [RL14]
    else $error("phase 1 left mid state before its first pulse");

  property p_cfg_hold;
    st_q == ST_RUN && $past(st_q) == ST_RUN |-> $stable(phase_count);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) // [RL15]
    else $error("phase count changed while running");
endmodule
`default_nettype wire

/* File: phase_count_detect_and_interleave_bench.sv */
// Self-checking bench for phase detection, output configuration and registers
`timescale 1ns/100ps
`default_nettype none
module phase_count_detect_and_interleave_bench;
  import phase_cfg_pkg::*;
  localparam int DET = 20;
  logic clk = 1'b0;
  logic rst_n, enable, ramp_ok, reg_wr, reg_rd, clr, lock, go, off;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, mdem, sdem;
  logic [4:0] rosc, pout, poe, pmid, pulsed;
  logic [3:0] tie, cmp;
  logic [2:0] sinks, cnt_q;
  logic overlap;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  // ----------------------------------------------------------------------
  // Design, partner and clock
  // ----------------------------------------------------------------------
  phase_count_detect #(.DETECT_CNT(DET)) phase_count_detect_i (
    .clk(clk), .rst_n(rst_n), .enable(enable), .phase_sense_strap_2(cmp[0]),
    .phase_sense_strap_3(cmp[1]), .phase_sense_strap_4(cmp[2]),
    .second_rail_sense_strap(cmp[3]), .ramp_supply_sense_pin(ramp_ok), .rosc_code(rosc),
    .main_demand(mdem), .second_demand(sdem), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .strap_sink_on(sinks),
    .phase1_pulse_out(pout[0]), .phase1_pulse_oe(poe[0]), .phase1_pulse_mid(pmid[0]),
    .phase2_pulse_out(pout[1]), .phase2_pulse_oe(poe[1]), .phase2_pulse_mid(pmid[1]),
    .phase3_pulse_out(pout[2]), .phase3_pulse_oe(poe[2]), .phase3_pulse_mid(pmid[2]),
    .phase4_pulse_out(pout[3]), .phase4_pulse_oe(poe[3]), .phase4_pulse_mid(pmid[3]),
    .second_rail_pulse_out(pout[4]), .second_rail_pulse_oe(poe[4]),
    .second_rail_pulse_mid(pmid[4]), .phase_count(cnt_q), .second_rail_off(off),
    .soft_start_go(go), .supply_low_lockout(lock));
  strap_driver_model strap_driver_model_i (.clk(clk), .clr(clr), .tie(tie), .sink_on(sinks),
    .pout(pout), .poe(poe), .pmid(pmid), .strap_cmp(cmp), .pulsed(pulsed), .overlap(overlap));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // A hang ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // Compare, register and closing tasks
  // ----------------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // Read data is registered, so it is settled one cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1; reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk8("reg_rdata", exp, reg_rdata);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset value, read back, and an unmapped write that must not land
  task automatic reg_test();
    reg_read(8'hf7, 8'h00);
    reg_write(8'hf7, 8'h25);
    reg_write(8'h10, 8'hff);
    reg_read(8'hf7, 8'h25);
    reg_read(8'h10, 8'h00);
    $display("test registers done");
  endtask

  // Full start-up with one strap pattern, then modulation and a strap change
  task automatic run_detect(input logic [3:0] t, input logic [2:0] cnt);
    logic [3:0] oe_exp;
    int n;
    case (cnt)
      3'h1:    oe_exp = 4'h1;
      3'h2:    oe_exp = 4'h5;
      3'h3:    oe_exp = 4'h7;
      default: oe_exp = 4'hf;
    endcase
    @(negedge clk);
    enable = 1'b0; tie = t; clr = 1'b1; mdem = 8'h00; sdem = 8'h00;
    @(negedge clk);
    enable = 1'b1; clr = 1'b0; n = 0;
    @(negedge clk);
    while (go !== 1'b1 && n < DET + 10) begin
      chk8("phase1 out", 8'h00, {7'h0, pout[0]});
      if (n == 3) chk8("sinks on", 8'h07, {5'h0, sinks});
      @(negedge clk);
      n++;
    end
    chk8("detect length ok", 8'h01, {7'h0, n >= DET && n <= DET + 3});
    chk8("phase_count", {5'h0, cnt}, {5'h0, cnt_q});
    chk8("second_rail_off", {7'h0, t[3]}, {7'h0, off});
    chk8("sinks off", 8'h00, {5'h0, sinks});
    chk8("mid", 8'h1f, {3'h0, pmid});
    repeat (2) @(negedge clk);
    chk8("oe", {3'h0, ~t[3], oe_exp}, {3'h0, poe});
    mdem = 8'hf0; sdem = 8'hf0;
    repeat (1300) @(negedge clk);
    chk8("pulsed", {3'h0, ~t[3], oe_exp}, {3'h0, pulsed});
    chk8("mid left", 8'h00, {3'h0, pmid & poe});
    if (cnt > 3'h1) chk8("overlap", 8'h01, {7'h0, overlap});
    tie = ~t;
    repeat (5) @(negedge clk);
    chk8("count held", {5'h0, cnt}, {5'h0, cnt_q});
    reg_read(8'hf8, {3'h0, 1'b1, t[3], cnt});
    chk8("oe held", {3'h0, ~t[3], oe_exp}, {3'h0, poe});
    $display("test straps %b done", t);
  endtask

  // Ramp supply lockout only while enabled
  task automatic lockout_test();
    @(negedge clk);
    ramp_ok = 1'b0;
    repeat (2) @(negedge clk);
    chk8("lockout on", 8'h01, {7'h0, lock});
    chk8("outs forced", 8'h00, {3'h0, pout & poe});
    enable = 1'b0;
    repeat (2) @(negedge clk);
    chk8("lockout gated", 8'h00, {7'h0, lock});
    ramp_ok = 1'b1;
    $display("test lockout done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    static logic [3:0] ties [8] = '{4'h0, 4'h4, 4'h5, 4'h7, 4'h8, 4'hc, 4'hd, 4'hf};
    static logic [2:0] cnts [8] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h4, 3'h3, 3'h2, 3'h1};
    rst_n = 1'b0; enable = 1'b0; ramp_ok = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; mdem = 8'h00; sdem = 8'h00;
    rosc = 5'h1f; clr = 1'b1; tie = 4'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk8("count at reset", 8'h04, {5'h0, cnt_q});
    reg_test();
    for (int i = 0; i < 8; i++) run_detect(ties[i], cnts[i]);
    lockout_test();
    reg_write(8'hf7, 8'h00);
    run_detect(4'h0, 3'h4);
    results();
  end
endmodule
`default_nettype wire

/* File: ramp_phase_channel.sv */
// One interleaved triangle ramp and dual-edge pulse comparator
`timescale 1ns/100ps
`default_nettype none
module ramp_phase_channel #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  input  wire logic          clk,      // System clock
  input  wire logic          rst_s_n,  // Synchronised reset
  input  wire logic          run,      // Modulation allowed
  input  wire logic [AW-1:0] acc,      // Shared oscillator phase
  input  wire logic [AW-1:0] offset,   // This channel's phase shift
  input  wire logic [DW-1:0] demand,   // Error amplifier level
  output logic               pulse_q   // Registered pulse
);
  logic [AW-1:0] ph;
  logic [AW-2:0] tri_v;

  // Triangle valley sits at phase zero so the pulse centres on it
  assign ph    = acc + offset;
  assign tri_v = ph[AW-1] ? ~ph[AW-2:0] : ph[AW-2:0];

  // Both edges move with demand; full demand gives near full duty
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= run && (demand > tri_v[AW-2 -: DW]);
    end
  end
endmodule
`default_nettype wire

/* File: strap_driver_model.sv */
// Strap pins and external gate drivers facing the phase detection block
`timescale 1ns/100ps
`default_nettype none
module strap_driver_model (
  input  wire logic       clk,       // System clock
  input  wire logic       clr,       // Clear pulse history
  input  wire logic [3:0] tie,       // Tied high: strap 2, 3, 4, second rail
  input  wire logic [2:0] sink_on,   // Sinks, straps 4..2
  input  wire logic [4:0] pout,      // Pulse levels, second rail on top
  input  wire logic [4:0] poe,       // Output enables
  input  wire logic [4:0] pmid,      // Mid level flags
  output logic      [3:0] strap_cmp, // Comparator results
  output logic      [4:0] pulsed,    // Driver saw a real pulse
  output logic            overlap    // Two main drivers on at once
);
  logic flip_q = 1'b0;

  // A floating untied strap wanders, so never hold a stable level
  always_ff @(posedge clk) flip_q <= ~flip_q;

  // Tied pin is above threshold; the sink pulls an untied pin low
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      strap_cmp[i] = tie[i] ? 1'b1 : (sink_on[i] ? 1'b0 : flip_q);
    end
    strap_cmp[3] = tie[3];
  end

  // Only a driven pin out of mid level counts as a pulse
  always_ff @(posedge clk) begin
    if (clr) begin
      pulsed <= '0;
      overlap <= 1'b0;
    end else begin
      pulsed <= pulsed | (pout & poe & ~pmid);
      if ($countones(pout[3:0] & poe[3:0]) > 1) overlap <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: strap_phase_decode.sv */
// Strap-level to main-rail phase count decoder
`timescale 1ns/100ps
`default_nettype none
module strap_phase_decode (
  input  wire logic       tied_2,  // Strap 2 above threshold
  input  wire logic       tied_3,  // Strap 3 above threshold
  input  wire logic       tied_4,  // Strap 4 above threshold
  output logic [2:0]      count    // Decoded main phase count
);
  import phase_cfg_pkg::*;

  // Unlisted combinations fall back to the widest match
  always_comb begin
    if (tied_2 && tied_3 && tied_4) begin
      count = PH_1;
    end else if (tied_2 && tied_4) begin
      count = PH_2;
    end else if (tied_4) begin
      count = PH_3;
    end else begin
      count = PH_4;
    end
  end
endmodule
`default_nettype wire
